/* File: core/sys_support_pkg.sv */
package sys_support_pkg;

  // Divider selections
  localparam logic       DIV_BY_3        = 1'b0;
  localparam logic       DIV_BY_4        = 1'b1;
  localparam logic [1:0] DIV3_LAST       = 2'h2;
  localparam logic [1:0] DIV4_LAST       = 2'h3;
  localparam logic [1:0] DIV_CNT_RST     = 2'h0;
  localparam logic [1:0] DIV3_HIGH_CNT   = 2'h1;
  localparam logic [1:0] DIV4_HIGH_CNT   = 2'h2;

  // Reset synchroniser depth and reset values
  localparam int         RST_SYNC_STAGES = 2;
  localparam logic       NMI_RST         = 1'b0;

  // Pin input synchroniser depth
  localparam int         PIN_SYNC_STAGES = 3;

  // Sustained tri-state release: cycles driven high before floating
  localparam int         STS_PARK_NS     = 25;
  localparam int         CLK_PERIOD_NS   = 25;
  localparam logic [1:0] STS_PARK_CYC    =
    2'((STS_PARK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0] STS_TURN_CYC    =
    2'((STS_PARK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0]
  {
    STS_IDLE  = 2'b00,
    STS_DRIVE = 2'b01,
    STS_PARK  = 2'b10,
    STS_TURN  = 2'b11
  } sts_state_e;

endpackage

/* File: core/bus_clock_divider.sv */
`timescale 1ns/1ps
module bus_clock_divider
(
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  input  wire logic div_sel_i,
  output logic      bus_clock_divided_out_o,
  output logic      bus_clk_rise_o,
  output logic      bus_clk_fall_o
);

  logic [1:0] cnt_q;
  logic [1:0] last_cyc;
  logic [1:0] high_cyc;
  logic       clk_d;

  assign last_cyc = (div_sel_i == sys_support_pkg::DIV_BY_4) ?
                    sys_support_pkg::DIV4_LAST :
                    sys_support_pkg::DIV3_LAST;
  assign high_cyc = (div_sel_i == sys_support_pkg::DIV_BY_4) ?
                    sys_support_pkg::DIV4_HIGH_CNT :
                    sys_support_pkg::DIV3_HIGH_CNT;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
      cnt_q <= sys_support_pkg::DIV_CNT_RST;
    else if (cnt_q >= last_cyc)
      cnt_q <= sys_support_pkg::DIV_CNT_RST;
    else
      cnt_q <= cnt_q + 2'h1;
  end

  // High for the first counts, low for the rest
  assign clk_d = (cnt_q >= high_cyc) ? 1'b0 : 1'b1;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
      bus_clock_divided_out_o <= 1'b0;
    else
      bus_clock_divided_out_o <= clk_d; // [RULE_01]
  end

  // One-cycle enables marking edges of the divided clock
  assign bus_clk_rise_o = rst_b_i && clk_d && !bus_clock_divided_out_o;
  assign bus_clk_fall_o = rst_b_i && !clk_d && bus_clock_divided_out_o;

endmodule

/* File: core/bus_clock_reset_error_nmi.sv */
`timescale 1ns/1ps
// How it works
// [RULE_01] Bus clock is system clock divided by three or four, selectable.
// [RULE_02] Sampled parity error low raises the CPU non-maskable interrupt.
// [RULE_03] Sampled system error low raises the CPU non-maskable interrupt.
// [RULE_04] Any agent may pulse parity or system error low to report faults.
// [RULE_05] Reset returns all state machines and registers to defaults.
// [RULE_06] Reset pin is asynchronous both edges; source gives clean release.
// [RULE_07] ISA reset drive output is derived from the system reset input.
// [RULE_08] During hard reset all CPU-directed outputs are driven low.
// [RULE_09] Sustained line is driven high one clock before floating.
// [RULE_10] New owner waits one clock after release before driving.
// [RULE_11] Names ending in _b or _n are active low; others active high, except the active-low sts_line_i and sts_line_o.
// [RULE_12] Divided clock leaves on its own pin and returns buffered.
// [RULE_13] Bus signals are generated or sampled on returned bus clock edges.
// [RULE_14] Reset release passes a two-stage synchroniser before use.
module bus_clock_reset_error_nmi
(
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  input  wire logic div_sel_i,
  input  wire logic bus_clk_i,
  input  wire logic parity_err_n_i,
  input  wire logic system_err_n_i,
  input  wire logic nmi_clear_i,
  input  wire logic cpu_irq_req_i,
  input  wire logic ignore_numeric_error_req_i,
  input  wire logic sys_mgmt_irq_req_i,
  input  wire logic alt_cpu_reset_req_i,
  input  wire logic cpu_clock_stop_req_i,
  input  wire logic fast_gate_a20_req_i,
  input  wire logic sts_req_i,
  input  wire logic sts_assert_i,
  input  wire logic sts_line_i,
  output logic      bus_clock_divided_out_o,
  output logic      bus_clk_rise_o,
  output logic      bus_clk_fall_o,
  output logic      isa_reset_drive_o,
  output logic      cpu_irq_o,
  output logic      nmi_o,
  output logic      ignore_numeric_error_out_n_o,
  output logic      sys_mgmt_irq_out_n_o,
  output logic      alt_cpu_reset_out_n_o,
  output logic      cpu_clock_stop_out_n_o,
  output logic      fast_gate_a20_out_o,
  output logic      sts_line_o,
  output logic      sts_line_oe_n_o,
  output logic      sts_owned_o,
  output logic      internal_rst_b_o
);

  logic [sys_support_pkg::RST_SYNC_STAGES-1:0] rst_sync_q;
  logic                                        rst_int_b;
  logic [sys_support_pkg::PIN_SYNC_STAGES-1:0] perr_sync_q;
  logic [sys_support_pkg::PIN_SYNC_STAGES-1:0] serr_sync_q;
  logic [sys_support_pkg::PIN_SYNC_STAGES-1:0] bclk_sync_q;
  logic [sys_support_pkg::PIN_SYNC_STAGES-1:0] sts_sync_q;
  logic                                        perr_act_q;
  logic                                        serr_act_q;
  logic                                        sts_lvl_q;
  logic                                        perr_rise;
  logic                                        serr_rise;
  logic                                        nmi_q;
  logic                                        irq_q;
  logic                                        ign_q;
  logic                                        mgmt_irq_q;
  logic                                        alt_rst_q;
  logic                                        clk_stop_q;
  logic                                        a20_q;
  logic                                        isa_rst_q;
  logic                                        ret_rise;
  logic                                        ret_fall;
  sys_support_pkg::sts_state_e                 sts_q;
  sys_support_pkg::sts_state_e                 sts_d;
  logic [1:0]                                  sts_cnt_q;
  logic                                        sts_out_q;
  logic                                        sts_oe_n_q;

  // Three-stage capture of an outside level; change counts on agreement
  function automatic logic agreed
  (
    input logic [sys_support_pkg::PIN_SYNC_STAGES-1:0] s,
    input logic                                        prev
  );
    agreed = (s[2] == s[1]) ? s[2] : prev;
  endfunction

  // Level newly agreed low while the filtered level is still inactive
  function automatic logic newly_low
  (
    input logic [sys_support_pkg::PIN_SYNC_STAGES-1:0] s,
    input logic                                        act
  );
    newly_low = !s[2] && !s[1] && !act;
  endfunction

  // Edge seen between the second and third stage
  function automatic logic stage_edge
  (
    input logic [sys_support_pkg::PIN_SYNC_STAGES-1:0] s,
    input logic                                        to_high
  );
    stage_edge = (s[1] == to_high) && (s[2] != to_high);
  endfunction

  // Asserts at once with the pin, releases after two clean clocks
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rst_sync_q <= '0; // [RULE_06]
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1}; // [RULE_14]
  end

  assign rst_int_b        = rst_sync_q[1];
  assign internal_rst_b_o = rst_int_b;

  bus_clock_divider u_div
  (
    .clk_sys_i               (clk_sys_i),
    .rst_b_i                 (rst_int_b),
    .div_sel_i               (div_sel_i),
    .bus_clock_divided_out_o (bus_clock_divided_out_o),
    .bus_clk_rise_o          (),
    .bus_clk_fall_o          ()
  );

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_int_b)
    begin
      perr_sync_q <= '1;
      serr_sync_q <= '1;
      bclk_sync_q <= '0;
      sts_sync_q  <= '1;
    end
    else
    begin
      perr_sync_q <= {perr_sync_q[1:0], parity_err_n_i};
      serr_sync_q <= {serr_sync_q[1:0], system_err_n_i};
      bclk_sync_q <= {bclk_sync_q[1:0], bus_clk_i};
      sts_sync_q  <= {sts_sync_q[1:0], sts_line_i};
    end
  end

  // Filtered levels; error levels kept active high internally
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_int_b) // [RULE_05]
    begin
      perr_act_q <= 1'b0;
      serr_act_q <= 1'b0;
      sts_lvl_q  <= 1'b1;
    end
    else
    begin
      perr_act_q <= ~agreed(perr_sync_q, ~perr_act_q); // [RULE_11]
      serr_act_q <= ~agreed(serr_sync_q, ~serr_act_q); // [RULE_11]
      sts_lvl_q  <= agreed(sts_sync_q, sts_lvl_q);
    end
  end

  // One-cycle set request on a freshly asserted error
  assign perr_rise = newly_low(perr_sync_q, perr_act_q);
  assign serr_rise = newly_low(serr_sync_q, serr_act_q);

  // Edges of the returned bus clock for bus-side timing; at divide
  // by three one phase lasts a single clock, too short for the
  // agreement filter, so edges come from stages two and three
  assign ret_rise       = stage_edge(bclk_sync_q, 1'b1);
  assign ret_fall       = stage_edge(bclk_sync_q, 1'b0);
  assign bus_clk_rise_o = ret_rise; // [RULE_13]
  assign bus_clk_fall_o = ret_fall; // [RULE_13]

  // Sticky NMI; a new error beats a clear in the same cycle
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_int_b)
      nmi_q <= sys_support_pkg::NMI_RST; // [RULE_08]
    else if (perr_rise) // [RULE_02]
      nmi_q <= 1'b1;
    else if (serr_rise) // [RULE_03]
      nmi_q <= 1'b1;
    else if (nmi_clear_i)
      nmi_q <= 1'b0;
  end

  // CPU-directed outputs held low through reset
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_int_b) // [RULE_08]
    begin
      irq_q      <= 1'b0;
      ign_q      <= 1'b0;
      mgmt_irq_q <= 1'b0;
      alt_rst_q  <= 1'b0;
      clk_stop_q <= 1'b0;
      a20_q      <= 1'b0;
    end
    else
    begin
      irq_q      <= cpu_irq_req_i;
      ign_q      <= ~ignore_numeric_error_req_i;
      mgmt_irq_q <= ~sys_mgmt_irq_req_i;
      alt_rst_q  <= ~alt_cpu_reset_req_i;
      clk_stop_q <= ~cpu_clock_stop_req_i;
      a20_q      <= fast_gate_a20_req_i;
    end
  end

  // Reset drive active high while internal reset is held
  always_ff @(posedge clk_sys_i)
  begin
    isa_rst_q <= ~rst_int_b; // [RULE_07]
  end

  // Gate low (reset drive forced high) while the raw pin is low, without waiting for a clock
  assign cpu_irq_o                    = irq_q & rst_b_i; // [RULE_08]
  assign nmi_o                        = nmi_q & rst_b_i;
  assign ignore_numeric_error_out_n_o = ign_q & rst_b_i;
  assign sys_mgmt_irq_out_n_o         = mgmt_irq_q & rst_b_i;
  assign alt_cpu_reset_out_n_o        = alt_rst_q & rst_b_i;
  assign cpu_clock_stop_out_n_o       = clk_stop_q & rst_b_i;
  assign fast_gate_a20_out_o          = a20_q & rst_b_i;
  assign isa_reset_drive_o            = isa_rst_q | ~rst_b_i; // [RULE_07]

  // Sustained tri-state ownership
  always_comb
  begin
    sts_d = sts_q;
    case (sts_q)
      sys_support_pkg::STS_IDLE:
        if (sts_req_i && sts_lvl_q)
          sts_d = sys_support_pkg::STS_DRIVE;
      sys_support_pkg::STS_DRIVE:
        if (!sts_req_i)
          sts_d = sys_support_pkg::STS_PARK;
      sys_support_pkg::STS_PARK:
        if (sts_cnt_q >= sys_support_pkg::STS_PARK_CYC)
          sts_d = sys_support_pkg::STS_TURN; // [RULE_09]
      sys_support_pkg::STS_TURN:
        if (sts_cnt_q >= sys_support_pkg::STS_TURN_CYC)
          sts_d = sys_support_pkg::STS_IDLE; // [RULE_10]
      default:
        sts_d = sys_support_pkg::STS_IDLE;
    endcase
  end

  // Starts in turnaround so nothing drives straight out of reset
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_int_b)
      sts_q <= sys_support_pkg::STS_TURN; // [RULE_10]
    else
      sts_q <= sts_d;
  end

  // Cycles spent in the current ownership state
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_int_b)
      sts_cnt_q <= 2'h0;
    else if (sts_d != sts_q)
      sts_cnt_q <= 2'h1;
    else if (sts_cnt_q != 2'h3)
      sts_cnt_q <= sts_cnt_q + 2'h1;
  end

  // Registered pin drive; enable low while driving
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_int_b)
    begin
      sts_out_q  <= 1'b1;
      sts_oe_n_q <= 1'b1;
    end
    else
    begin
      case (sts_d)
        sys_support_pkg::STS_DRIVE:
        begin
          sts_out_q  <= ~sts_assert_i;
          sts_oe_n_q <= 1'b0;
        end
        sys_support_pkg::STS_PARK:
        begin
          sts_out_q  <= 1'b1; // [RULE_09]
          sts_oe_n_q <= 1'b0;
        end
        default:
        begin
          sts_out_q  <= 1'b1;
          sts_oe_n_q <= 1'b1;
        end
      endcase
    end
  end

  assign sts_line_o      = sts_out_q;
  assign sts_line_oe_n_o = sts_oe_n_q;
  assign sts_owned_o     = (sts_q == sys_support_pkg::STS_DRIVE);

endmodule

/* File: verification/sys_support_sva.sv */
`timescale 1ns/1ps
module sys_support_sva
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic div_sel_i,
  input wire logic bus_clk_i,
  input wire logic parity_err_n_i,
  input wire logic system_err_n_i,
  input wire logic nmi_clear_i,
  input wire logic bus_clock_divided_out_o,
  input wire logic bus_clk_rise_o,
  input wire logic bus_clk_fall_o,
  input wire logic isa_reset_drive_o,
  input wire logic cpu_irq_o,
  input wire logic nmi_o,
  input wire logic ignore_numeric_error_out_n_o,
  input wire logic sys_mgmt_irq_out_n_o,
  input wire logic alt_cpu_reset_out_n_o,
  input wire logic cpu_clock_stop_out_n_o,
  input wire logic fast_gate_a20_out_o,
  input wire logic sts_line_o,
  input wire logic sts_line_oe_n_o,
  input wire logic internal_rst_b_o
);
  wire bco = bus_clock_divided_out_o;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  a_div_three:
    assert property ($rose(bco) && !div_sel_i |=> !bco[*2] ##1 bco)
    else $error("divide by three shape");
  a_div_four:
    assert property ($rose(bco) && div_sel_i |=> bco ##1 !bco[*2] ##1 bco)
    else $error("divide by four shape");
  a_reset_quiet:
    assert property (disable iff (1'b0) !rst_b_i |-> isa_reset_drive_o &&
      !cpu_irq_o && !nmi_o && !fast_gate_a20_out_o &&
      !ignore_numeric_error_out_n_o && !sys_mgmt_irq_out_n_o &&
      !alt_cpu_reset_out_n_o && !cpu_clock_stop_out_n_o)
    else $error("outputs not low in reset");
  a_sync_release:
    assert property ($rose(rst_b_i) |->
      !internal_rst_b_o ##1 !internal_rst_b_o ##1 internal_rst_b_o)
    else $error("reset release not two stages");
  a_isa_release:
    assert property ($rose(internal_rst_b_o) |->
      isa_reset_drive_o ##1 !isa_reset_drive_o)
    else $error("isa reset release wrong");
  a_parity_nmi:
    assert property ($fell(parity_err_n_i) ##1 !parity_err_n_i[*3]
      |-> ##[0:3] nmi_o)
    else $error("parity error gave no nmi");
  a_system_nmi:
    assert property ($fell(system_err_n_i) ##1 !system_err_n_i[*3]
      |-> ##[0:3] nmi_o)
    else $error("system error gave no nmi");
  a_nmi_hold:
    assert property (nmi_o && !nmi_clear_i |=> nmi_o)
    else $error("nmi dropped without clear");
  a_bus_rise:
    assert property (internal_rst_b_o && $rose(bus_clk_i)
      |-> ##[1:5] bus_clk_rise_o)
    else $error("bus clock rise missed");
  a_bus_fall:
    assert property (internal_rst_b_o && $fell(bus_clk_i)
      |-> ##[1:5] bus_clk_fall_o)
    else $error("bus clock fall missed");
  a_park_high:
    assert property ($rose(sts_line_oe_n_o) |-> $past(sts_line_o))
    else $error("line floated without high park");
  a_turn_gap:
    assert property ($rose(sts_line_oe_n_o) |=> sts_line_oe_n_o)
    else $error("line retaken without gap");
endmodule

bind bus_clock_reset_error_nmi sys_support_sva chk (.*);

/* File: verification/pci_far_side_model.sv */
`timescale 1ns/1ps
module pci_far_side_model
(
  input  wire logic       clk_sys_i,
  input  wire logic       bus_clock_divided_out_o,
  input  wire logic       perr_go_i,
  input  wire logic       serr_go_i,
  input  wire logic [3:0] len_i,
  output logic            parity_err_n_o,
  output logic            system_err_n_o,
  output logic            bus_clk_o
);
  logic [3:0] perr_q = 4'h0;
  logic [3:0] serr_q = 4'h0;

  // Board buffer delay on the returned clock
  assign #3 bus_clk_o = bus_clock_divided_out_o;

  // Lines are pulled up; an agent pulses them low for len cycles
  always @(posedge clk_sys_i)
  begin
    if (perr_go_i)
      perr_q <= len_i;
    else if (perr_q != 4'h0)
      perr_q <= perr_q - 4'h1;
    if (serr_go_i)
      serr_q <= len_i;
    else if (serr_q != 4'h0)
      serr_q <= serr_q - 4'h1;
  end

  assign parity_err_n_o = (perr_q == 4'h0);
  assign system_err_n_o = (serr_q == 4'h0);
endmodule

/* File: verification/bus_clock_reset_error_nmi_bench.sv */
`timescale 1ns/1ps
module bus_clock_reset_error_nmi_bench;
  logic       clk_sys_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic       div_sel_i = sys_support_pkg::DIV_BY_4;
  logic       nmi_clear_i = 1'b0;
  logic       sts_req_i = 1'b0;
  logic       sts_assert_i = 1'b0;
  logic       perr_go = 1'b0;
  logic       serr_go = 1'b0;
  logic [3:0] err_len = 4'h0;
  logic       agent_drv = 1'b0;
  logic       agent_val = 1'b1;
  logic [5:0] req = 6'h3f;
  logic [3:0] outn;
  logic       bus_clk_i, parity_err_n_i, system_err_n_i, sts_line_i;
  logic       bus_clock_divided_out_o, bus_clk_rise_o, isa_reset_drive_o;
  logic       cpu_irq_o, nmi_o, a20, sts_line_o, sts_line_oe_n_o;
  logic       internal_rst_b_o;
  logic       bus_clk_fall_o, owned;
  int         bad_count = 0;
  int         check_count = 0;

  always #12.5 clk_sys_i = ~clk_sys_i;
  // Pull-up holds the shared line high when nobody drives it
  assign sts_line_i = !sts_line_oe_n_o ? sts_line_o :
                      agent_drv ? agent_val : 1'b1;

  bus_clock_reset_error_nmi uut
  (
    .cpu_irq_req_i                (req[0]),
    .ignore_numeric_error_req_i   (req[1]),
    .sys_mgmt_irq_req_i           (req[2]),
    .alt_cpu_reset_req_i          (req[3]),
    .cpu_clock_stop_req_i         (req[4]),
    .fast_gate_a20_req_i          (req[5]),
    .ignore_numeric_error_out_n_o (outn[0]),
    .sys_mgmt_irq_out_n_o         (outn[1]),
    .alt_cpu_reset_out_n_o        (outn[2]),
    .cpu_clock_stop_out_n_o       (outn[3]),
    .fast_gate_a20_out_o          (a20),
    .bus_clk_fall_o               (bus_clk_fall_o),
    .sts_owned_o                  (owned),
    .*
  );

  pci_far_side_model far
  (
    .clk_sys_i               (clk_sys_i),
    .bus_clock_divided_out_o (bus_clock_divided_out_o),
    .perr_go_i               (perr_go),
    .serr_go_i               (serr_go),
    .len_i                   (err_len),
    .parity_err_n_o          (parity_err_n_i),
    .system_err_n_o          (system_err_n_i),
    .bus_clk_o               (bus_clk_i)
  );

  task automatic chk(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic step;
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wait_lv(ref logic s, input logic v);
    int i;
    #1;
    for (i = 0; i < 40 && s !== v; i++)
      step();
    if (s !== v)
    begin
      bad_count++;
      wrap_up();
    end
  endtask

  task automatic do_reset(input logic sel);
    cyc(1);
    rst_b_i <= 1'b0;
    div_sel_i <= sel;
    cyc(3);
    rst_b_i <= 1'b1;
    cyc(8);
  endtask

  task automatic pulse(input logic ser, input logic [3:0] len);
    cyc(1);
    perr_go <= !ser;
    serr_go <= ser;
    err_len <= len;
    cyc(1);
    perr_go <= 1'b0;
    serr_go <= 1'b0;
  endtask

  task automatic t_reset;
    cyc(2);
    #1;
    chk(isa_reset_drive_o, 1'b1);
    chk(|{cpu_irq_o, nmi_o, a20, outn}, 1'b0);
    cyc(1);
    rst_b_i <= 1'b1;
    wait_lv(internal_rst_b_o, 1'b1);
    wait_lv(isa_reset_drive_o, 1'b0);
    cyc(3);
    #1;
    chk(cpu_irq_o & a20 & ~|outn, 1'b1);
    cyc(1);
    rst_b_i <= 1'b0;
    #1;
    chk(|{cpu_irq_o, a20, outn}, 1'b0);
    chk(isa_reset_drive_o, 1'b1);
    cyc(3);
    rst_b_i <= 1'b1;
  endtask

  task automatic t_div(input logic sel, input int hi, input int per);
    int h;
    int p;
    int n;
    int f;
    do_reset(sel);
    wait_lv(bus_clock_divided_out_o, 1'b0);
    wait_lv(bus_clock_divided_out_o, 1'b1);
    h = 0;
    p = 0;
    n = 0;
    f = 0;
    while (bus_clock_divided_out_o === 1'b1 && p < 9)
    begin
      h++;
      p++;
      step();
    end
    while (bus_clock_divided_out_o === 1'b0 && p < 9)
    begin
      p++;
      step();
    end
    chk(h == hi, 1'b1);
    chk(p == per, 1'b1);
    repeat (12)
    begin
      n += int'(bus_clk_rise_o === 1'b1);
      f += int'(bus_clk_fall_o === 1'b1);
      step();
    end
    chk(n == 12 / per, 1'b1);
    chk(f == 12 / per, 1'b1);
  endtask

  task automatic t_err(input logic ser);
    pulse(ser, 4'hc);
    wait_lv(nmi_o, 1'b1);
    chk(nmi_o, 1'b1);
    cyc(1);
    nmi_clear_i <= 1'b1;
    cyc(1);
    nmi_clear_i <= 1'b0;
    cyc(12);
    #1;
    chk(nmi_o, 1'b0);
    pulse(ser, 4'h4);
    wait_lv(nmi_o, 1'b1);
    cyc(10);
    #1;
    chk(nmi_o, 1'b1);
    do_reset(sys_support_pkg::DIV_BY_4);
    #1;
    chk(nmi_o, 1'b0);
  endtask

  task automatic t_sts;
    logic last;
    int   i;
    cyc(1);
    sts_req_i <= 1'b1;
    wait_lv(sts_line_oe_n_o, 1'b0);
    cyc(1);
    sts_assert_i <= 1'b1;
    cyc(3);
    #1;
    chk(sts_line_i, 1'b0);
    chk(owned, 1'b1);
    cyc(1);
    sts_assert_i <= 1'b0;
    sts_req_i <= 1'b0;
    last = 1'b0;
    for (i = 0; i < 8; i++)
    begin
      step();
      if (sts_line_oe_n_o === 1'b0)
        last = sts_line_i;
    end
    chk(last, 1'b1);
    cyc(1);
    agent_drv <= 1'b1;
    agent_val <= 1'b0;
    cyc(5);
    sts_req_i <= 1'b1;
    cyc(6);
    #1;
    chk(sts_line_oe_n_o, 1'b1);
    chk(owned, 1'b0);
    cyc(1);
    agent_val <= 1'b1;
    cyc(1);
    agent_drv <= 1'b0;
    wait_lv(sts_line_oe_n_o, 1'b0);
    chk(owned, 1'b1);
    cyc(1);
    sts_req_i <= 1'b0;
  endtask

  initial
  begin
    t_reset();
    t_div(sys_support_pkg::DIV_BY_3, 1, 3);
    t_div(sys_support_pkg::DIV_BY_4, 2, 4);
    t_err(1'b0);
    t_err(1'b1);
    t_sts();
    wrap_up();
  end
endmodule
